// file: rfsm_pkg.sv
// Package with register map, reset values and field positions of the fault status bank.
package rfsm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_TYPES = 4;
  localparam logic [7:0] OFS_REF_FAULT_ISR = 8'h02;
  localparam logic [7:0] OFS_INPUT23_FAULT_LATCH = 8'h06;
  localparam logic [7:0] OFS_INPUT01_FAULT_LATCH = 8'h07;
  localparam logic [7:0] OFS_INPUT23_FAULT_ENABLE = 8'h08;
  localparam logic [7:0] OFS_INPUT01_FAULT_ENABLE = 8'h09;
  localparam logic [7:0] OFS_FAULT_CLEAR = 8'h20;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h21;
  localparam logic [7:0] OFS_GPIO_SEL01 = 8'h22;
  localparam logic [7:0] OFS_GPIO_SEL23 = 8'h23;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_FAULT_ENABLE = 8'h66;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] RST_GPIO_SEL = 8'h00;
  localparam int BIT_ABSENT = 0;
  localparam int BIT_ONE_PERIOD = 1;
  localparam int BIT_ROUGH_RATE = 2;
  localparam int BIT_QUALIFY = 3;
  localparam int LO_FIELD = 0;
  localparam int HI_FIELD = 4;
endpackage

// file: rfsm_sync.sv
// Two-flop synchroniser for a bus of pin levels.
`timescale 1ns/1ns
`default_nettype none
module rfsm_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// file: rfsm_sticky.sv
// Sticky flag bank where a hardware set wins over a software clear.
`timescale 1ns/1ns
`default_nettype none
module rfsm_sticky #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clr_in,
  output logic [WIDTH-1:0] flag_r
);
  logic [WIDTH-1:0] flag_nxt;
  assign flag_nxt = (flag_r & ~clr_in) | set_in;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      flag_r <= '0;
    else
      flag_r <= flag_nxt;
  end
endmodule
`default_nettype wire

// file: rfsm_top.sv
// Reference fault status bank: sticky latches, fault enables, interrupt status and pin select.
//
// Functional notes
// (R1) Input 0 absent flag sets on loss pin
// (R2) Loss input chosen from any general pin
// (R3) Input 0 one-period flag on single-cycle fault
// (R4) Input 0 rough-rate flag on frequency fault
// (R5) Input 0 qualify flag on timer expiry
// (R6) Input 1 flags in bits 4 to 7
// (R7) Latch flags set regardless of enables
// (R8) Input 2 enables in bits 3:0
// (R9) Enable zero disables, one enables
// (R10) Disabled fault kept out of status 0x02
// (R11) Enables never touch latch at 0x06
// (R12) Input 3 enables in bits 7:4
// (R13) Inputs 2 and 3 latched at 0x06
// (R14) Flags hold until software clears them
`timescale 1ns/1ns
`default_nettype none
module rfsm_top #(
  parameter int NUM_GPIO = 8,
  parameter int SEL_W = 3
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [NUM_GPIO-1:0] gpio_in,
  input wire logic [3:0] one_period_fail,
  input wire logic [3:0] rough_rate_fail,
  input wire logic [3:0] qualify_expired,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq
);
  // --------------------------------------------------------------
  // Pin synchronisation and loss-input selection
  // --------------------------------------------------------------
  logic [NUM_GPIO-1:0] gpio_s;
  logic [3:0] one_period_s;
  logic [3:0] rough_rate_s;
  logic [3:0] qualify_s;
  logic [7:0] gpio_sel01_r;
  logic [7:0] gpio_sel23_r;
  logic [3:0] absent_lvl;
  logic [3:0] absent_prev_r;
  logic [3:0] absent_rise;

  rfsm_sync #(.WIDTH(NUM_GPIO + 12)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in({gpio_in, one_period_fail, rough_rate_fail, qualify_expired}),
    .sync_out({gpio_s, one_period_s, rough_rate_s, qualify_s})
  );

  function automatic logic pick_pin(input logic [NUM_GPIO-1:0] pins,
                                    input logic [SEL_W-1:0] sel);
    pick_pin = pins[sel];
  endfunction

  assign absent_lvl[0] = pick_pin(gpio_s, gpio_sel01_r[SEL_W-1:0]); // R2
  assign absent_lvl[1] = pick_pin(gpio_s, gpio_sel01_r[4 +: SEL_W]); // R2
  assign absent_lvl[2] = pick_pin(gpio_s, gpio_sel23_r[SEL_W-1:0]); // R2
  assign absent_lvl[3] = pick_pin(gpio_s, gpio_sel23_r[4 +: SEL_W]); // R2
  assign absent_rise = absent_lvl & ~absent_prev_r; // R1

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      absent_prev_r <= 4'h0;
    else
      absent_prev_r <= absent_lvl;
  end

  // --------------------------------------------------------------
  // Event vectors, one nibble per input
  // --------------------------------------------------------------
  logic [15:0] fault_ev;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_ev
      assign fault_ev[gi*4 + rfsm_pkg::BIT_ABSENT] = absent_rise[gi]; // R1 R6
      assign fault_ev[gi*4 + rfsm_pkg::BIT_ONE_PERIOD] = one_period_s[gi]; // R3 R6
      assign fault_ev[gi*4 + rfsm_pkg::BIT_ROUGH_RATE] = rough_rate_s[gi]; // R4 R6
      assign fault_ev[gi*4 + rfsm_pkg::BIT_QUALIFY] = qualify_s[gi]; // R5 R6
    end
  endgenerate

  // --------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------
  logic wr_clear;
  logic wr_en01;
  logic wr_en23;
  logic wr_irq_en;
  logic wr_sel01;
  logic wr_sel23;
  logic rd_isr;
  assign wr_clear = wr && (addr == rfsm_pkg::OFS_FAULT_CLEAR);
  assign wr_en01 = wr && (addr == rfsm_pkg::OFS_INPUT01_FAULT_ENABLE);
  assign wr_en23 = wr && (addr == rfsm_pkg::OFS_INPUT23_FAULT_ENABLE);
  assign wr_irq_en = wr && (addr == rfsm_pkg::OFS_IRQ_ENABLE);
  assign wr_sel01 = wr && (addr == rfsm_pkg::OFS_GPIO_SEL01);
  assign wr_sel23 = wr && (addr == rfsm_pkg::OFS_GPIO_SEL23);
  assign rd_isr = rd && (addr == rfsm_pkg::OFS_REF_FAULT_ISR);

  // --------------------------------------------------------------
  // Sticky latches and enables
  // --------------------------------------------------------------
  logic [7:0] input01_fault_latch;
  logic [7:0] input23_fault_latch;
  logic [7:0] input01_fault_enable_r;
  logic [7:0] input23_fault_enable_r;
  logic [7:0] irq_enable_r;
  logic [15:0] latch_clr;
  logic [15:0] latch_all;
  // Clear register bit0 clears input01 latch, bit1 input23 latch.
  assign latch_clr = {{8{wr_clear & wdata[1]}}, {8{wr_clear & wdata[0]}}}; // R14

  // Latches are fed straight from events; enables never enter here.
  rfsm_sticky #(.WIDTH(16)) u_latch (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_in(fault_ev), // R7 R11
    .clr_in(latch_clr), // R14
    .flag_r(latch_all)
  );
  assign input01_fault_latch = latch_all[7:0];
  assign input23_fault_latch = latch_all[15:8]; // R13

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      input01_fault_enable_r <= rfsm_pkg::RST_FAULT_ENABLE;
      input23_fault_enable_r <= rfsm_pkg::RST_FAULT_ENABLE;
      irq_enable_r <= rfsm_pkg::RST_IRQ_ENABLE;
      gpio_sel01_r <= rfsm_pkg::RST_GPIO_SEL;
      gpio_sel23_r <= rfsm_pkg::RST_GPIO_SEL;
    end
    else
    begin
      if (wr_en01)
        input01_fault_enable_r <= wdata;
      if (wr_en23)
        input23_fault_enable_r <= wdata; // R8 R12
      if (wr_irq_en)
        irq_enable_r <= {4'h0, wdata[3:0]};
      if (wr_sel01)
        gpio_sel01_r <= wdata;
      if (wr_sel23)
        gpio_sel23_r <= wdata;
    end
  end

  // --------------------------------------------------------------
  // Reference fault interrupt status, one bit per input
  // --------------------------------------------------------------
  logic [15:0] enables_all;
  logic [15:0] gated_ev;
  logic [3:0] isr_set;
  logic [3:0] isr_clr;
  logic [3:0] isr_r;
  logic irq_nxt;
  assign enables_all = {input23_fault_enable_r, input01_fault_enable_r};
  assign gated_ev = fault_ev & enables_all; // R9 R10
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_isr
      assign isr_set[gi] = |gated_ev[gi*4 +: 4]; // R10
    end
  endgenerate
  // Reading the interrupt status clears it; a coincident event wins.
  assign isr_clr = {4{rd_isr}};

  rfsm_sticky #(.WIDTH(4)) u_isr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .set_in(isr_set),
    .clr_in(isr_clr),
    .flag_r(isr_r)
  );

  assign irq_nxt = |(isr_r & irq_enable_r[3:0]);

  // --------------------------------------------------------------
  // Read data and interrupt output
  // --------------------------------------------------------------
  logic [7:0] rdata_nxt;
  assign rdata_nxt =
    !rd ? 8'h00 :
    (addr == rfsm_pkg::OFS_REF_FAULT_ISR) ? {4'h0, isr_r} :
    (addr == rfsm_pkg::OFS_INPUT23_FAULT_LATCH) ? input23_fault_latch :
    (addr == rfsm_pkg::OFS_INPUT01_FAULT_LATCH) ? input01_fault_latch :
    (addr == rfsm_pkg::OFS_INPUT23_FAULT_ENABLE) ? input23_fault_enable_r :
    (addr == rfsm_pkg::OFS_INPUT01_FAULT_ENABLE) ? input01_fault_enable_r :
    (addr == rfsm_pkg::OFS_IRQ_ENABLE) ? irq_enable_r :
    (addr == rfsm_pkg::OFS_GPIO_SEL01) ? gpio_sel01_r :
    (addr == rfsm_pkg::OFS_GPIO_SEL23) ? gpio_sel23_r :
    8'h00;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata <= 8'h00;
      irq <= 1'b0;
    end
    else
    begin
      rdata <= rdata_nxt;
      irq <= irq_nxt;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  a_absent_sets: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
    absent_rise[0] |=> input01_fault_latch[0])
    else $error("input0 absent flag not set");
  a_sel_routes: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
    (gpio_sel01_r[SEL_W-1:0] == 3'd0) |-> (absent_lvl[0] == gpio_s[0]))
    else $error("loss pin select wrong");
  a_one_period: assert property (@(posedge ref_clk) disable iff (!rstn) // R3
    one_period_s[0] |=> input01_fault_latch[1])
    else $error("one-period flag not set");
  a_rough_rate: assert property (@(posedge ref_clk) disable iff (!rstn) // R4
    rough_rate_s[0] |=> input01_fault_latch[2])
    else $error("rough-rate flag not set");
  a_qualify_timer: assert property (@(posedge ref_clk) disable iff (!rstn) // R5
    qualify_s[0] |=> input01_fault_latch[3])
    else $error("qualify flag not set");
  a_input1_period: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
    one_period_s[1] |=> input01_fault_latch[5])
    else $error("input1 one-period flag not set");
  a_input1_qualify: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
    qualify_s[1] |=> input01_fault_latch[7])
    else $error("input1 qualify flag not set");
  a_unmasked_latch: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
    (rough_rate_s[2] && !input23_fault_enable_r[2]) |=> input23_fault_latch[2])
    else $error("latch suppressed by enable");
  a_mask_gates: assert property (@(posedge ref_clk) disable iff (!rstn) // R10
    (!input23_fault_enable_r[4] && !input23_fault_enable_r[5] && !input23_fault_enable_r[6]
     && !input23_fault_enable_r[7] && rd_isr) |=> !isr_r[3])
    else $error("disabled fault reached status");
  a_sticky_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // R14
    (input01_fault_latch[1] && !(wr_clear && wdata[0])) |=> input01_fault_latch[1])
    else $error("flag dropped without clear");
  a_read_data: assert property (@(posedge ref_clk) disable iff (!rstn) // R8
    (rd && addr == rfsm_pkg::OFS_INPUT23_FAULT_ENABLE && !wr_en23)
      |=> (rdata == $past(input23_fault_enable_r)))
    else $error("enable readback wrong");

  // --------------------------------------------------------------
  // Latch, pin select, status, interrupt and enable assertions
  // --------------------------------------------------------------
  // The remaining input 1 flags are checked one kind at a time.
  a_input1_absent: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
    absent_rise[1] |=> input01_fault_latch[4])
    else $error("input1 absent flag not set");
  a_input1_rough: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
    rough_rate_s[1] |=> input01_fault_latch[6])
    else $error("input1 rough-rate flag not set");
  a_sel_input1: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
    absent_lvl[1] == gpio_s[gpio_sel01_r[4 +: SEL_W]])
    else $error("input1 loss pin select wrong");
  a_sel_input2: assert property (@(posedge ref_clk) disable iff (!rstn) // R2
    absent_lvl[2] == gpio_s[gpio_sel23_r[SEL_W-1:0]])
    else $error("input2 loss pin select wrong");
  // A latch bit only rises on an event and only falls on a clear.
  a_absent_quiet: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
    (!absent_rise[0] && !input01_fault_latch[0])
      |=> !input01_fault_latch[0])
    else $error("input0 absent flag set without rising pin");
  a_input01_all: assert property (@(posedge ref_clk) disable iff (!rstn) // R7
    (fault_ev[7:0] != 8'h00)
      |=> ((input01_fault_latch & $past(fault_ev[7:0])) == $past(fault_ev[7:0])))
    else $error("input01 event lost from latch");
  a_input23_all: assert property (@(posedge ref_clk) disable iff (!rstn) // R13
    (fault_ev[15:8] != 8'h00)
      |=> ((input23_fault_latch & $past(fault_ev[15:8])) == $past(fault_ev[15:8])))
    else $error("input23 event lost from latch");
  a_enable_no_touch: assert property (@(posedge ref_clk) disable iff (!rstn) // R11
    ((wr_en23 || wr_en01) && (fault_ev == 16'h0000) && !wr_clear)
      |=> (latch_all == $past(latch_all)))
    else $error("enable write changed a latch");
  a_latch_ro: assert property (@(posedge ref_clk) disable iff (!rstn) // R14
    (wr && (addr == rfsm_pkg::OFS_INPUT01_FAULT_LATCH) && (fault_ev[7:0] == 8'h00))
      |=> (input01_fault_latch == $past(input01_fault_latch)))
    else $error("write to latch changed it");
  a_clear01: assert property (@(posedge ref_clk) disable iff (!rstn) // R14
    (wr_clear && wdata[0] && (fault_ev[7:0] == 8'h00))
      |=> (input01_fault_latch == 8'h00))
    else $error("input01 latch not cleared");
  a_clear23: assert property (@(posedge ref_clk) disable iff (!rstn) // R14
    (wr_clear && wdata[1] && (fault_ev[15:8] == 8'h00))
      |=> (input23_fault_latch == 8'h00))
    else $error("input23 latch not cleared");
  a_clear_other: assert property (@(posedge ref_clk) disable iff (!rstn) // R14
    (wr_clear && !wdata[1])
      |=> ((input23_fault_latch & $past(input23_fault_latch)) == $past(input23_fault_latch)))
    else $error("input23 latch lost without its clear");
  a_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn) // R14
    (wr_clear && wdata[0] && one_period_s[0])
      |=> input01_fault_latch[1])
    else $error("clear beat a coincident fault");

  // Every enabled fault of an input must reach its status bit.
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_isr_chk
      a_isr_sets: assert property (@(posedge ref_clk) disable iff (!rstn) // R9
        (|(fault_ev[gi*4 +: 4] & enables_all[gi*4 +: 4])) |=> isr_r[gi])
        else $error("enabled fault missed status");
    end
  endgenerate

  a_isr_blocked2: assert property (@(posedge ref_clk) disable iff (!rstn) // R10
    (((fault_ev[11:8] & input23_fault_enable_r[3:0]) == 4'h0) && rd_isr)
      |=> !isr_r[2])
    else $error("disabled input2 fault reached status");
  a_isr_input3: assert property (@(posedge ref_clk) disable iff (!rstn) // R12
    ((fault_ev[15:12] & input23_fault_enable_r[7:4]) != 4'h0)
      |=> isr_r[3])
    else $error("enabled input3 fault missed status");
  a_isr_holds: assert property (@(posedge ref_clk) disable iff (!rstn) // R14
    ((isr_r != 4'h0) && !rd_isr)
      |=> ((isr_r & $past(isr_r)) == $past(isr_r)))
    else $error("status bit dropped without read");
  // The interrupt line follows the enabled status bits one cycle later.
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rstn) // R10
    ((isr_r & irq_enable_r[3:0]) != 4'h0) |=> irq)
    else $error("interrupt missing");
  a_irq_quiet: assert property (@(posedge ref_clk) disable iff (!rstn) // R10
    ((isr_r & irq_enable_r[3:0]) == 4'h0) |=> !irq)
    else $error("interrupt without enabled status");
  a_enable_write: assert property (@(posedge ref_clk) disable iff (!rstn) // R12
    wr_en23 |=> (input23_fault_enable_r == $past(wdata)))
    else $error("input23 enable write lost");
  a_enable01_write: assert property (@(posedge ref_clk) disable iff (!rstn) // R9
    wr_en01 |=> (input01_fault_enable_r == $past(wdata)))
    else $error("input01 enable write lost");
endmodule
`default_nettype wire

// file: rfsm_phy_model.sv
// Model of the line interface device that signals loss of input on a general pin.
`timescale 1ns/1ns
`default_nettype none
module rfsm_phy_model (
  input wire logic ref_clk,
  input wire logic [2:0] loss_pin,
  input wire logic loss_on,
  output logic [7:0] gpio
);
  // The device drives its loss pins low when no loss is reported, so no pin floats.
  always_ff @(posedge ref_clk)
  begin
    gpio <= loss_on ? (8'h01 << loss_pin) : 8'h00;
  end
endmodule
`default_nettype wire

// file: test_rfsm_top.sv
// Self-checking bench for the reference fault status bank.
`timescale 1ns/1ns
`default_nettype none
module test_rfsm_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] gpio_in;
  logic [3:0] one_period_fail = 4'h0;
  logic [3:0] rough_rate_fail = 4'h0;
  logic [3:0] qualify_expired = 4'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic [2:0] loss_pin = 3'h0;
  logic loss_on = 1'b0;
  int mismatches = 0;
  int checks_done = 0;
  logic [7:0] v;
  // Each row: fault kind, input index, expected latch byte after a clear and one fault pulse.
  localparam logic [15:0] ROWS [12] = '{16'h1002, 16'h1120, 16'h1202, 16'h1320,
    16'h2004, 16'h2140, 16'h2204, 16'h2340, 16'h3008, 16'h3180, 16'h3208, 16'h3380};
  always #25 ref_clk = ~ref_clk;
  rfsm_top #(.NUM_GPIO(8), .SEL_W(3)) rfsm_top_i (.ref_clk(ref_clk), .rstn(rstn),
    .gpio_in(gpio_in), .one_period_fail(one_period_fail), .rough_rate_fail(rough_rate_fail),
    .qualify_expired(qualify_expired), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));
  rfsm_phy_model rfsm_phy_model_i (.ref_clk(ref_clk), .loss_pin(loss_pin),
    .loss_on(loss_on), .gpio(gpio_in));
  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bus_rd(a, d);
    chk(nm, exp, d);
  endtask
  task pulse(input int k, input int i);
    @(posedge ref_clk);
    if (k == 1) one_period_fail[i] <= 1'b1;
    if (k == 2) rough_rate_fail[i] <= 1'b1;
    if (k == 3) qualify_expired[i] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    one_period_fail <= 4'h0;
    rough_rate_fail <= 4'h0;
    qualify_expired <= 4'h0;
    repeat (4) @(posedge ref_clk);
  endtask
  task loss(input logic [2:0] p, input logic on);
    @(posedge ref_clk);
    loss_pin <= p;
    loss_on <= on;
    repeat (6) @(posedge ref_clk);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_chk("latch01 reset", 8'h07, 8'h00);
    rd_chk("latch23 reset", 8'h06, 8'h00);
    rd_chk("enable23 reset", 8'h08, 8'h66);
    rd_chk("unmapped", 8'hFF, 8'h00);
    $display("reset test done");
    for (int r = 0; r < 12; r++)
    begin
      bus_wr(8'h20, 8'h03);
      pulse(ROWS[r][15:12], ROWS[r][11:8]);
      rd_chk("fault latch", ROWS[r][9] ? 8'h06 : 8'h07, ROWS[r][7:0]);
    end
    $display("fault table test done");
    bus_wr(8'h22, 8'h25);
    bus_wr(8'h20, 8'h03);
    loss(3'h7, 1'b1);
    rd_chk("unselected pin", 8'h07, 8'h00);
    loss(3'h5, 1'b1);
    loss(3'h5, 1'b0);
    rd_chk("input0 absent", 8'h07, 8'h01);
    loss(3'h2, 1'b1);
    rd_chk("input1 absent", 8'h07, 8'h11);
    bus_wr(8'h07, 8'hFF);
    rd_chk("read only latch", 8'h07, 8'h11);
    bus_wr(8'h20, 8'h01);
    rd_chk("latch cleared", 8'h07, 8'h00);
    one_period_fail <= 4'h1;
    repeat (3) @(posedge ref_clk);
    bus_wr(8'h20, 8'h01);
    one_period_fail <= 4'h0;
    repeat (4) @(posedge ref_clk);
    rd_chk("set beats clear", 8'h07, 8'h02);
    $display("loss pin test done");
    bus_wr(8'h21, 8'h0C);
    bus_wr(8'h08, 8'h00);
    bus_rd(8'h02, v);
    chk("status before clear", 8'h0F, v);
    bus_wr(8'h20, 8'h02);
    pulse(2, 2);
    rd_chk("masked latch", 8'h06, 8'h04);
    rd_chk("masked status", 8'h02, 8'h00);
    chk("irq masked", 8'h00, {7'h00, irq});
    bus_wr(8'h08, 8'h04);
    pulse(2, 2);
    chk("irq enabled", 8'h01, {7'h00, irq});
    rd_chk("enabled status", 8'h02, 8'h04);
    repeat (3) @(posedge ref_clk);
    chk("irq after read", 8'h00, {7'h00, irq});
    bus_wr(8'h08, 8'h80);
    pulse(3, 3);
    pulse(3, 2);
    rd_chk("input3 status", 8'h02, 8'h08);
    rd_chk("both latched", 8'h06, 8'h8C);
    bus_wr(8'h20, 8'h02);
    bus_wr(8'h23, 8'h03);
    loss(3'h3, 1'b1);
    rd_chk("input2 absent", 8'h06, 8'h01);
    bus_wr(8'h09, 8'h01);
    rd_chk("enable01 readback", 8'h09, 8'h01);
    bus_wr(8'h21, 8'h01);
    loss(3'h5, 1'b1);
    chk("irq input0", 8'h01, {7'h00, irq});
    rd_chk("input0 status", 8'h02, 8'h01);
    $display("enable test done");
    loss(3'h5, 1'b0);
    loss(3'h5, 1'b1);
    chk("irq before reset", 8'h01, {7'h00, irq});
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irq in reset", 8'h00, {7'h00, irq});
    rstn <= 1'b1;
    rd_chk("latch01 after reset", 8'h07, 8'h00);
    rd_chk("enable01 after reset", 8'h09, 8'h66);
    rd_chk("select after reset", 8'h22, 8'h00);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
